/* File: core/ddc_chan_pkg.sv */
// Contract
// RULE1 - Asym bit high: programmable filter runs 32 asymmetric taps, first tap on newest sample.
// RULE2 - Q-delay bit delays Q stream by one filter input sample.
// RULE3 - I-delay bit delays I stream by one filter input sample.
// RULE4 - Overflow source: 0 compensating, 1 coarse gain, 2/3 programmable filter; overflow mode only.
// RULE5 - Input select: 0-3 single-ended A-D, 4-5 differential A-B, 6-7 diagnostic.
// RULE6 - Software picking a differential input also enables the differential receivers. The bank drives no receiver enable; software must set it elsewhere.
// RULE7 - Dual format accepts only samples whose A/B flag equals the select bit.
// RULE8 - Format field: 0 14-bit, 1 16-bit, 2 12+exponent, 3 dual 12+exponent.
// RULE9 - Polarity bit inverts input sample top bit, offset binary to two's complement.
// RULE10 - On selected peak sync, copy counter to count register, then clear counter.
// RULE11 - Input peak mode compares abs of top 11 bits to quarter-step threshold.
// RULE12 - Peak mode 0 counts samples over threshold; 1 counts selected overflow.
// RULE13 - Count register holds previous sync period events; counter saturates at 255.
// RULE14 - Fine gain: low eight bits at 30, upper six at bits 0-5 of 31.
// RULE15 - Fine gain stage multiplies signal by fine gain over 1024.
// RULE16 - Fine gain is double buffered; new value applies on gain sync event.
// RULE17 - Peak counter increments at most once per processed sample clock.
// shared constants and carrier types of one down-converter channel register bank
// assumes a single 100 MHz clock and an AHB-Lite master with word-only single transfers
package ddc_chan_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PFILT      = 8'h1a;
    localparam logic [7:0] IDX_INPUT      = 8'h1b;
    localparam logic [7:0] IDX_PEAK_CTL   = 8'h1c;
    localparam logic [7:0] IDX_PEAK_CNT   = 8'h1d;
    localparam logic [7:0] IDX_GAIN_LO    = 8'h1e;
    localparam logic [7:0] IDX_GAIN_HI    = 8'h1f;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h21;

    // reset values
    localparam logic [7:0] RST_PFILT    = 8'h00;
    localparam logic [7:0] RST_INPUT    = 8'h00;
    localparam logic [7:0] RST_PEAK_CTL = 8'h1d;
    localparam logic [7:0] RST_GAIN     = 8'h00;

    // field positions
    localparam int PF_ASYM_BIT    = 0;
    localparam int PF_QDLY_BIT    = 1;
    localparam int PF_IDLY_BIT    = 2;
    localparam int PF_OVSRC_LSB   = 3;
    localparam int IN_SEL_LSB     = 0;
    localparam int IN_AB_BIT      = 3;
    localparam int IN_FMT_LSB     = 4;
    localparam int IN_POL_BIT     = 7;
    localparam int PK_SYNC_LSB    = 0;
    localparam int PK_THR_LSB     = 3;
    localparam int PK_MODE_BIT    = 5;
    localparam int GAIN_HI_WIDTH  = 6;
    localparam int GAIN_FRAC_BITS = 10;

    // interrupt status bits
    localparam int IRQ_SYNC_BIT = 0;
    localparam int IRQ_SAT_BIT  = 1;
    localparam int IRQ_GAIN_BIT = 2;

    localparam logic [7:0]  PEAK_MAX  = 8'hff;
    localparam logic [10:0] THR_STEP  = 11'h100;

    typedef enum logic [1:0] {
        FMT_14     = 2'h0,
        FMT_16     = 2'h1,
        FMT_12EXP  = 2'h2,
        FMT_DUAL   = 2'h3
    } format_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } sample_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] i;
        logic [15:0] q;
    } iq_type;

endpackage

/* File: core/ddc_chan_regs.sv */
// register bank, input selection and formatting, peak counter and fine gain of one channel
// assumes one AHB-Lite master, sample pins asynchronous to hclk, sync and overflow strobes on hclk
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
module ddc_chan_regs
    import ddc_chan_pkg::*;
(
    input  wire logic        hclk,                    // 100 MHz clock
    input  wire logic        hresetn,                 // async reset, active low
    input  wire logic        hsel,                    // slave select
    input  wire logic [31:0] haddr,                   // byte address
    input  wire logic [1:0]  htrans,                  // transfer type
    input  wire logic        hwrite,                  // write when high
    input  wire logic [2:0]  hsize,                   // transfer size
    input  wire logic [31:0] hwdata,                  // write data
    input  wire logic        hready,                  // bus ready
    output logic             hreadyout,               // slave ready
    output logic             hresp,                   // always okay
    output logic [31:0]      hrdata,                  // read data
    input  wire logic [15:0] port_a,                  // single-ended pin bus a
    input  wire logic [15:0] port_b,                  // single-ended pin bus b
    input  wire logic [15:0] port_c,                  // single-ended pin bus c
    input  wire logic [15:0] port_d,                  // single-ended pin bus d
    input  wire logic [15:0] diff_a,                  // differential receiver a
    input  wire logic [15:0] diff_b,                  // differential receiver b
    input  wire logic [15:0] diag_sample,             // internal diagnostic source
    input  wire logic [7:0]  sync_sources,            // sync strobes by peak sync code
    input  wire logic        gain_sync,               // selected gain sync strobe
    input  wire logic        compensating_filter_ovf, // compensating_filter overflow
    input  wire logic        coarse_ovf,              // coarse gain overflow
    input  wire logic        programmable_filter_ovf, // programmable_filter overflow
    input  wire iq_type      pfilt_in,                // programmable_filter input stream
    output iq_type           pfilt_out,               // delay-aligned filter input stream
    output logic             prog_filter_asym_enable, // filter asymmetric mode
    input  wire sample_type  gain_in,                 // fine gain input
    output sample_type       gain_out,                // fine gain output
    output sample_type       chan_sample,             // formatted channel sample
    output logic             irq                      // level interrupt
);

    // register file
    logic [7:0]  pfilt_q;
    logic [7:0]  input_q;
    logic [7:0]  peak_ctl_q;
    logic [7:0]  peak_cnt_q;
    logic [7:0]  gain_lo_q;
    logic [7:0]  gain_hi_q;
    logic [2:0]  irq_status_q;
    logic [2:0]  irq_mask_q;
    logic [13:0] gain_active_q;

    // bus data phase state
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [7:0]  bus_idx_q;

    logic        bus_take;
    logic [7:0]  wr_byte;
    logic [2:0]  wr_ones;

    // pin synchronisers: six buses of sixteen bits
    logic [15:0] pin_raw  [6];
    logic [15:0] pin_s1_q [6];
    logic [15:0] pin_s2_q [6];

    logic [15:0] raw_sel;
    logic [15:0] raw_pol;
    logic        ab_match;
    logic [15:0] fmt_data;
    logic        fmt_valid;
    format_type  fmt_mode;

    logic [7:0]  peak_ctr_q;
    logic [10:0] peak_abs;
    logic [10:0] peak_thr;
    logic        ovf_pick;
    logic        peak_hit;
    logic        peak_sync;

    logic [15:0] i_hold_q;
    logic [15:0] q_hold_q;

    logic signed [31:0] gain_prod;
    logic signed [21:0] gain_scaled;

    // input select code to pin bus index; 6 is diagnostic
    function automatic logic [2:0] port_index(input logic [2:0] sel);
        logic [2:0] idx;
        idx = 3'h6;
        case (sel)
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: idx = sel;
            default: idx = 3'h6;
        endcase
        return idx;
    endfunction

    // raw word to 16-bit two's complement
    function automatic logic [15:0] format_word(input logic [15:0] raw, input format_type mode);
        logic [15:0] res;
        logic [2:0]  expo;
        res  = raw;
        expo = raw[3:1];
        case (mode)
            FMT_14:   res = {raw[15:2], 2'h0};
            FMT_16:   res = raw;
            FMT_12EXP,
            FMT_DUAL: res = 16'($signed({raw[15:4], 4'h0}) >>> (3'h7 - expo));
            default:  res = raw;
        endcase
        return res;
    endfunction

    // AHB-Lite slave, zero wait states
    assign bus_take  = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_byte   = hwdata[7:0];
    assign wr_ones   = hwdata[2:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            bus_idx_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= bus_take & hwrite;
            rd_pend_q <= bus_take & ~hwrite;
            bus_idx_q <= (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'hff;
        end
    end

    // read mux of register flops; unmapped words read zero
    always_comb begin
        hrdata = 32'h00000000;
        if (rd_pend_q) begin
            case (bus_idx_q)
                IDX_PFILT:      hrdata = 32'(pfilt_q);
                IDX_INPUT:      hrdata = 32'(input_q);
                IDX_PEAK_CTL:   hrdata = 32'(peak_ctl_q);
                IDX_PEAK_CNT:   hrdata = 32'(peak_cnt_q);
                IDX_GAIN_LO:    hrdata = 32'(gain_lo_q);
                IDX_GAIN_HI:    hrdata = 32'(gain_hi_q);
                IDX_IRQ_STATUS: hrdata = 32'(irq_status_q);
                IDX_IRQ_MASK:   hrdata = 32'(irq_mask_q);
                default:        hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pfilt_q    <= RST_PFILT;
            input_q    <= RST_INPUT;
            peak_ctl_q <= RST_PEAK_CTL;
            gain_lo_q  <= RST_GAIN;
            gain_hi_q  <= RST_GAIN;
            irq_mask_q <= 3'h0;
        end else if (wr_pend_q) begin
            case (bus_idx_q)
                IDX_PFILT:     pfilt_q    <= wr_byte;
                IDX_INPUT:     input_q    <= wr_byte;
                IDX_PEAK_CTL:  peak_ctl_q <= wr_byte;
                IDX_GAIN_LO:   gain_lo_q  <= wr_byte;                             // RULE14
                IDX_GAIN_HI:   gain_hi_q  <= {2'h0, wr_byte[GAIN_HI_WIDTH-1:0]}; // RULE14
                IDX_IRQ_MASK:  irq_mask_q <= wr_ones;
                default: ;
            endcase
        end
    end

    // input path
    assign pin_raw[0] = port_a;
    assign pin_raw[1] = port_b;
    assign pin_raw[2] = port_c;
    assign pin_raw[3] = port_d;
    assign pin_raw[4] = diff_a;
    assign pin_raw[5] = diff_b;

    // pins run on converter clocks, so each bit passes two flops
    for (genvar g = 0; g < 6; g++) begin : g_pin_sync
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pin_s1_q[g] <= 16'h0000;
                pin_s2_q[g] <= 16'h0000;
            end else begin
                pin_s1_q[g] <= pin_raw[g];
                pin_s2_q[g] <= pin_s1_q[g];
            end
        end
    end

    // the differential receiver enable lives elsewhere; software must set it too
    always_comb begin
        case (port_index(input_q[IN_SEL_LSB +: 3]))                          // RULE5
            3'h0: raw_sel = pin_s2_q[0];
            3'h1: raw_sel = pin_s2_q[1];
            3'h2: raw_sel = pin_s2_q[2];
            3'h3: raw_sel = pin_s2_q[3];
            3'h4: raw_sel = pin_s2_q[4];
            3'h5: raw_sel = pin_s2_q[5];
            default: raw_sel = diag_sample;
        endcase
    end

    assign fmt_mode  = format_type'(input_q[IN_FMT_LSB +: 2]);                // RULE8
    assign raw_pol   = {raw_sel[15] ^ input_q[IN_POL_BIT], raw_sel[14:0]};   // RULE9
    assign ab_match  = (raw_pol[0] == input_q[IN_AB_BIT]);
    assign fmt_valid = (fmt_mode != FMT_DUAL) | ab_match;                    // RULE7
    assign fmt_data  = format_word(raw_pol, fmt_mode);                       // RULE8

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_sample <= '0;
        end else begin
            chan_sample.valid <= fmt_valid;
            chan_sample.data  <= fmt_data;
        end
    end

    // peak counter
    // magnitude of the top 11 bits; -1024 gives 1024 and so reaches full scale
    assign peak_abs = chan_sample.data[15] ? 11'(-$signed(chan_sample.data[15:5]))
                                           : {1'b0, chan_sample.data[14:5]};
    assign peak_thr = 11'(THR_STEP * (11'(peak_ctl_q[PK_THR_LSB +: 2]) + 11'h001)); // RULE11

    always_comb begin
        case (pfilt_q[PF_OVSRC_LSB +: 2])                                    // RULE4
            2'h0:    ovf_pick = compensating_filter_ovf;
            2'h1:    ovf_pick = coarse_ovf;
            default: ovf_pick = programmable_filter_ovf;
        endcase
    end

    // one decision per clock, so at most one increment per processed sample
    assign peak_hit  = peak_ctl_q[PK_MODE_BIT] ? ovf_pick                    // RULE12 RULE17
                                               : (chan_sample.valid & (peak_abs >= peak_thr)); // RULE11
    assign peak_sync = sync_sources[peak_ctl_q[PK_SYNC_LSB +: 3]];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            peak_ctr_q <= 8'h00;
        end else if (peak_sync) begin
            peak_ctr_q <= {7'h00, peak_hit};                                  // RULE10
        end else if (peak_hit && peak_ctr_q != PEAK_MAX) begin
            peak_ctr_q <= peak_ctr_q + 8'h01;                                 // RULE13
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            peak_cnt_q <= 8'h00;
        end else if (peak_sync) begin
            peak_cnt_q <= peak_ctr_q;                                         // RULE10 RULE13
        end
    end

    // programmable filter input alignment
    assign prog_filter_asym_enable = pfilt_q[PF_ASYM_BIT];                   // RULE1

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            i_hold_q <= 16'h0000;
            q_hold_q <= 16'h0000;
        end else if (pfilt_in.valid) begin
            i_hold_q <= pfilt_in.i;
            q_hold_q <= pfilt_in.q;
        end
    end

    // a one-sample delay at the filter input is half an output sample
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pfilt_out <= '0;
        end else begin
            pfilt_out.valid <= pfilt_in.valid;
            pfilt_out.i     <= pfilt_q[PF_IDLY_BIT] ? i_hold_q : pfilt_in.i; // RULE3
            pfilt_out.q     <= pfilt_q[PF_QDLY_BIT] ? q_hold_q : pfilt_in.q; // RULE2
        end
    end

    // fine gain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_active_q <= 14'h0000;
        end else if (gain_sync) begin
            gain_active_q <= {gain_hi_q[GAIN_HI_WIDTH-1:0], gain_lo_q};       // RULE16 RULE14
        end
    end

    assign gain_prod   = $signed(gain_in.data) * $signed({2'b00, gain_active_q});
    assign gain_scaled = 22'(gain_prod >>> GAIN_FRAC_BITS);                   // RULE15

    // clamp to 16 bits rather than wrap on large gains
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_out <= '0;
        end else begin
            gain_out.valid <= gain_in.valid;
            if (gain_scaled > 22'sd32767) begin
                gain_out.data <= 16'h7fff;
            end else if (gain_scaled < -22'sd32768) begin
                gain_out.data <= 16'h8000;
            end else begin
                gain_out.data <= gain_scaled[15:0];                           // RULE15
            end
        end
    end

    // interrupts
    // hardware set wins over a same-cycle write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_q <= 3'h0;
        end else begin
            irq_status_q <= (irq_status_q & ~((wr_pend_q && bus_idx_q == IDX_IRQ_STATUS) ? wr_ones : 3'h0))
                          | {gain_sync,
                             peak_hit & ~peak_sync & (peak_ctr_q == PEAK_MAX - 8'h01),
                             peak_sync};
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

endmodule

/* File: core/ddc_chan_regs_end.sv */
// holds no logic
// assumes nothing

/* File: verif/ddc_chan_regs_assertions.sv */
// checker for the channel register bank: filter and gain streams, bus answers
// assumes it is bound into ddc_chan_regs and sees only that module's ports
`timescale 1ns/100ps
module ddc_chan_regs_assertions
    import ddc_chan_pkg::*;
(
    input wire logic        hclk,                    // clock
    input wire logic        hresetn,                 // reset, active low
    input wire logic        hsel,                    // select
    input wire logic [31:0] haddr,                   // byte address
    input wire logic [1:0]  htrans,                  // transfer type
    input wire logic        hwrite,                  // write
    input wire logic        hready,                  // bus ready
    input wire logic [31:0] hwdata,                  // write data
    input wire logic        hreadyout,               // slave ready
    input wire logic        hresp,                   // response
    input wire logic [31:0] hrdata,                  // read data
    input wire iq_type      pfilt_in,                // filter input stream
    input wire iq_type      pfilt_out,               // filter output stream
    input wire logic        prog_filter_asym_enable, // asymmetric mode
    input wire sample_type  gain_in,                 // gain input
    input wire sample_type  gain_out                 // gain output
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        pf_wr_q;
    logic        rd_q;
    logic [7:0]  pf_q;
    logic [15:0] li_q;
    logic [15:0] lq_q;
    // shadow of the filter control, for the delay checks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pf_wr_q <= 1'b0;
            rd_q    <= 1'b0;
            pf_q    <= 8'h00;
            li_q    <= 16'h0000;
            lq_q    <= 16'h0000;
        end else begin
            pf_wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h68;
            rd_q    <= hsel && hready && htrans[1] && !hwrite;
            if (pf_wr_q) pf_q <= hwdata[7:0];
            if (pfilt_in.valid) {li_q, lq_q} <= {pfilt_in.i, pfilt_in.q};
        end
    end
    sequence pf_addr_s;
        hsel && hready && htrans[1] && hwrite && haddr == 32'h68;
    endsequence
    sequence pf_write_s;
        pf_addr_s ##1 1'b1;
    endsequence
    AST_ASYM_SET: assert property (pf_write_s |=> prog_filter_asym_enable == $past(hwdata[0]))
        else $error("asym bit wrong");
    AST_ASYM_HOLD: assert property (!pf_wr_q |=> $stable(prog_filter_asym_enable))
        else $error("asym bit moved");
    AST_Q_PASS: assert property (pfilt_in.valid && !pf_q[1] |=> pfilt_out.q == $past(pfilt_in.q))
        else $error("q delayed");
    AST_Q_DELAY: assert property (pfilt_in.valid && pf_q[1] |=> pfilt_out.q == $past(lq_q))
        else $error("q not delayed");
    AST_I_PASS: assert property (pfilt_in.valid && !pf_q[2] |=> pfilt_out.i == $past(pfilt_in.i))
        else $error("i delayed");
    AST_I_DELAY: assert property (pfilt_in.valid && pf_q[2] |=> pfilt_out.i == $past(li_q))
        else $error("i not delayed");
    AST_FILT_VALID: assert property (pfilt_out.valid == $past(pfilt_in.valid))
        else $error("filter valid late");
    AST_GAIN_VALID: assert property (gain_out.valid == $past(gain_in.valid))
        else $error("gain valid late");
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not okay");
    AST_RD_IDLE: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("stray read data");
endmodule

bind ddc_chan_regs ddc_chan_regs_assertions ddc_chan_regs_assertions_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout,
    .hresp, .hrdata, .pfilt_in, .pfilt_out, .prog_filter_asym_enable, .gain_in, .gain_out
);

/* File: verif/adc_model.sv */
// behavioural converters on the six sample pin buses
// assumes the bench names the live bus; the rest show the inverted word
`timescale 1ns/100ps
module adc_model (
    input  wire logic [15:0] word,   // converter word
    input  wire logic [2:0]  live,   // 0-3 single a-d, 4-5 differential a-b
    output logic [15:0]      port_a, // single-ended a
    output logic [15:0]      port_b, // single-ended b
    output logic [15:0]      port_c, // single-ended c
    output logic [15:0]      port_d, // single-ended d
    output logic [15:0]      diff_a, // differential a
    output logic [15:0]      diff_b  // differential b
);
    // idle buses never copy the word, so a wrong pick cannot pass by luck
    always_comb begin
        port_a = (live == 3'h0) ? word : ~word;
        port_b = (live == 3'h1) ? word : ~word;
        port_c = (live == 3'h2) ? word : ~word;
        port_d = (live == 3'h3) ? word : ~word;
        diff_a = (live == 3'h4) ? word : ~word;
        diff_b = (live == 3'h5) ? word : ~word;
    end
endmodule

/* File: verif/ddc_channel_input_peak_gain_tb.sv */
// self-checking bench for the channel register bank
// assumes the converter model on the pins and an AHB-Lite master built from tasks here
`timescale 1ns/100ps
module ddc_channel_input_peak_gain_tb;
    import ddc_chan_pkg::*;
    typedef struct packed {
        logic [7:0]  cfg;
        logic [2:0]  live;
        logic [15:0] raw;
        logic        ok;
        logic [15:0] out;
    } row_type;
    localparam int NP = 10;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, prog_filter_asym_enable;
    logic        gain_sync;
    logic [1:0]  htrans;
    logic [2:0]  hsize, live, ovf;
    logic [31:0] haddr, hwdata, hrdata, c;
    logic [15:0] word, diag_sample, port_a, port_b, port_c, port_d, diff_a, diff_b;
    logic [7:0]  sync_sources;
    iq_type      pfilt_in, pfilt_out;
    sample_type  gain_in, gain_out, chan_sample;
    int          err_total = 0, tests_run = 0;
    row_type     rows [14] = '{
        '{8'h10, 3'h0, 16'h1234, 1'b1, 16'h1234}, '{8'h11, 3'h1, 16'h1234, 1'b1, 16'h1234},
        '{8'h12, 3'h2, 16'h1234, 1'b1, 16'h1234}, '{8'h13, 3'h3, 16'h1234, 1'b1, 16'h1234},
        '{8'h14, 3'h4, 16'h1234, 1'b1, 16'h1234}, '{8'h15, 3'h5, 16'h1234, 1'b1, 16'h1234},
        '{8'h16, 3'h7, 16'h1234, 1'b1, 16'h1234}, '{8'h17, 3'h7, 16'h1234, 1'b1, 16'h1234},
        '{8'h00, 3'h0, 16'h1237, 1'b1, 16'h1234}, '{8'h90, 3'h0, 16'h1234, 1'b1, 16'h9234},
        '{8'h20, 3'h0, 16'h7abf, 1'b1, 16'h7ab0}, '{8'h20, 3'h0, 16'h8006, 1'b1, 16'hf800},
        '{8'h38, 3'h0, 16'h7abf, 1'b1, 16'h7ab0}, '{8'h30, 3'h0, 16'h7abf, 1'b0, 16'h0000}};
    assign hready = hreadyout;
    ddc_chan_regs ddc_chan_regs_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .port_a, .port_b, .port_c, .port_d,
        .diff_a, .diff_b, .diag_sample, .sync_sources, .gain_sync, .compensating_filter_ovf(ovf[0]),
        .coarse_ovf(ovf[1]), .programmable_filter_ovf(ovf[2]), .pfilt_in, .pfilt_out,
        .prog_filter_asym_enable, .gain_in, .gain_out, .chan_sample, .irq);
    adc_model adc_model_inst (.word, .live, .port_a, .port_b, .port_c, .port_d, .diff_a, .diff_b);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // valid alternates so the previous valid sample differs from the previous cycle
    always @(posedge hclk) begin
        pfilt_in <= hresetn ? {~pfilt_in.valid, pfilt_in.i + 16'h0001, pfilt_in.q - 16'h0003} : '0;
    end
    task automatic finish_test;
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wait_rdy;
        for (int n = 0; n < 50; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        err_total++;
        finish_test();
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 8'h00, r);
    endtask
    task automatic pulse(input int b);
        sync_sources <= 8'h01 << b;
        @(posedge hclk);
        sync_sources <= 8'h00;
    endtask
    // two syncs n edges apart, then the count of the period between them
    task automatic period(input int b, input int n, output logic [31:0] r);
        pulse(b);
        repeat (n - 1) @(posedge hclk);
        pulse(b);
        rd(8'h74, r);
    endtask
    task automatic gain(input logic [15:0] d, input logic [15:0] want);
        gain_in <= {1'b1, d};
        @(posedge hclk);
        gain_in <= '0;
        @(posedge hclk);
        check(gain_out, {1'b1, want});
    endtask
    initial begin
        {hresetn, hsel, hwrite, gain_sync, ovf, gain_in} = '0;
        {htrans, haddr, hwdata, word, diag_sample, sync_sources, live} = '0;
        hsize = 3'b010;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(irq, 1'b0);
        for (int a = 8'h68; a <= 8'h88; a += 4) begin
            rd(8'(a), c);
            check(c, (a == 8'h70) ? 32'h1d : 32'h0);
        end
        wr(8'h74, 8'hff);
        rd(8'h74, c);
        check(c, 32'h0);
        wr(8'h88, 8'h55);
        rd(8'h88, c);
        check(c, 32'h0);
        foreach (rows[k]) begin
            word <= rows[k].raw;
            live <= rows[k].live;
            diag_sample <= (rows[k].live == 3'h7) ? rows[k].raw : ~rows[k].raw;
            wr(8'h6c, rows[k].cfg);
            repeat (4) @(posedge hclk);
            check(chan_sample.valid, rows[k].ok);
            if (rows[k].ok) check(chan_sample.data, rows[k].out);
        end
        wr(8'h68, 8'h07);
        rd(8'h68, c);
        check(c, 32'h07);
        check(prog_filter_asym_enable, 1'b1);
        wr(8'h6c, 8'h10);
        ovf <= 3'b111;
        for (int r = 0; r < 2; r++) begin
            for (int t = 0; t < 4; t++) begin
                word <= r ? 16'h8000 : 16'hc000;
                wr(8'h70, 8'((t << 3) | t));
                repeat (4) @(posedge hclk);
                period(t, NP, c);
                check(c, ((r ? 1024 : 512) >= 256 * (t + 1)) ? NP : 0);
            end
        end
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 3; k++) begin
                ovf <= 3'b001 << k;
                wr(8'h68, 8'(s << 3));
                wr(8'h70, 8'(8'h20 | (s + 4)));
                period(s + 4, NP, c);
                check(c, (k == ((s > 2) ? 2 : s)) ? NP : 0);
            end
        end
        wr(8'h78, 8'h00);
        wr(8'h7c, 8'hc2);
        gain(16'h1000, 16'h0000);
        gain_sync <= 1'b1;
        @(posedge hclk);
        gain_sync <= 1'b0;
        gain(16'h1000, 16'h0800);
        gain(16'hf000, 16'hf800);
        wr(8'h78, 8'hff);
        wr(8'h7c, 8'h3f);
        rd(8'h78, c);
        check(c, 32'hff);
        gain(16'h0100, 16'h0080);
        gain_sync <= 1'b1;
        @(posedge hclk);
        gain_sync <= 1'b0;
        gain(16'h0100, 16'h0fff);
        gain(16'h4000, 16'h7fff);
        ovf <= 3'b000;
        wr(8'h70, 8'h00);
        period(0, 300, c);
        check(c, 32'hff);
        rd(8'h74, c);
        check(c, 32'hff);
        rd(8'h80, c);
        check(c, 32'h07);
        check(irq, 1'b0);
        wr(8'h84, 8'h02);
        @(posedge hclk);
        check(irq, 1'b1);
        word <= 16'h0000;
        repeat (4) @(posedge hclk);
        pulse(0);
        wr(8'h80, 8'h02);
        @(posedge hclk);
        check(irq, 1'b0);
        rd(8'h80, c);
        check(c, 32'h05);
        finish_test();
    end
endmodule
